// >>> dv/fdsr_drive_model.sv
`timescale 1ns/1ps

module fdsr_drive_model
(
	// Clock, reset, bench control
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [5:0] cfg,
	input  wire logic       kick,
	// Drive pins
	output logic            write_protect_in,
	output logic            index_in,
	output logic            track_zero_in,
	output logic            read_data_in_n,
	output logic            second_drive_present_in,
	output logic            dma_ack_in_n,
	output logic            terminal_count_in
);
	logic [2:0] low_reg;

	// one read pulse, inactive edge at end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			low_reg <= 3'h0;
		else if (kick)
			low_reg <= 3'h4;
		else if (low_reg != 3'h0)
			low_reg <= low_reg - 3'h1;
	end
	// Held low long enough for the two-flop synchroniser
	assign read_data_in_n = (low_reg == 3'h0);
	assign {terminal_count_in, dma_ack_in_n, second_drive_present_in, track_zero_in, index_in, write_protect_in} = cfg;
endmodule : fdsr_drive_model

// >>> dv/fdsr_properties.sv
`timescale 1ns/1ps

module fdsr_properties
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// Host port and mode
	input wire logic [9:0] host_addr,
	input wire logic       host_wr_n,
	input wire logic [7:0] host_data_oe,
	input wire logic [1:0] status_mode,
	// Pin outputs
	input wire logic       dma_request_oe,
	input wire logic       fdc_irq_oe,
	input wire logic       dma_ack_gated_n,
	input wire logic       terminal_count_gated,
	input wire logic       drive_select0_out_n,
	input wire logic       drive_select1_out_n,
	input wire logic       motor0_out_n,
	input wire logic       motor1_out_n,
	input wire logic       soft_reset_n,
	input wire logic [1:0] tape_drive_sel
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// Address and mode steadiness, saturating at 7
	logic [9:0] addr_reg;
	logic [1:0] mode_reg;
	logic [2:0] same_reg;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			addr_reg <= 10'h000;
			mode_reg <= 2'h0;
			same_reg <= 3'h0;
		end
		else
		begin
			addr_reg <= host_addr;
			mode_reg <= status_mode;
			same_reg <= (host_addr == addr_reg && status_mode == mode_reg) ? same_reg + {2'h0, same_reg != 3'h7} : 3'h0;
		end
	end

	// ==========================================================
	// Properties
	chk_one_select: assert property (drive_select0_out_n || drive_select1_out_n)
		else $error("both drive selects active");
	chk_select_motor: assert property ((drive_select0_out_n || !motor0_out_n) && (drive_select1_out_n || !motor1_out_n))
		else $error("drive selected without its motor");
	chk_enh_pins: assert property (status_mode == fdsr_pkg::FDSR_MODE_ENHANCED && $past(status_mode) == fdsr_pkg::FDSR_MODE_ENHANCED && !$past(rst) |-> dma_request_oe && fdc_irq_oe)
		else $error("pins disabled in enhanced mode");
	chk_gated_inputs: assert property (!fdc_irq_oe |-> dma_ack_gated_n && !terminal_count_gated)
		else $error("ack or count passed while disabled");
	chk_oe_shape: assert property (host_data_oe inside {8'h00, 8'hff, 8'h03})
		else $error("odd data drive pattern");
	chk_basic_float: assert property (same_reg == 3'h7 && status_mode == fdsr_pkg::FDSR_MODE_BASIC && host_addr[9:1] == 9'h1f8 |-> host_data_oe == 8'h00)
		else $error("status driven in basic mode");
	chk_reset_values: assert property ($past(rst) |-> !soft_reset_n && drive_select0_out_n && drive_select1_out_n && motor0_out_n && motor1_out_n && tape_drive_sel == 2'h0)
		else $error("bad values after reset");
	chk_tape_write: assert property ($changed(tape_drive_sel) |-> $past(host_addr, 4) == fdsr_pkg::OFS_TAPE && (!$past(host_wr_n, 4) || !$past(host_wr_n, 5) || !$past(host_wr_n, 6)))
		else $error("tape select changed without write");

	cover property (!drive_select1_out_n);
	cover property ($changed(tape_drive_sel));
	cover property (host_data_oe == 8'h03);
endmodule : fdsr_properties

bind fdsr_regs fdsr_properties u_props (.clk, .rst, .host_addr, .host_wr_n, .host_data_oe, .status_mode,
	.dma_request_oe, .fdc_irq_oe, .dma_ack_gated_n, .terminal_count_gated, .drive_select0_out_n,
	.drive_select1_out_n, .motor0_out_n, .motor1_out_n, .soft_reset_n, .tape_drive_sel);

// >>> dv/tb.sv
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0, rst = 1'b1, host_rd_n = 1'b1, host_wr_n = 1'b1, drive_swap = 1'b0, kick = 1'b0;
	logic [9:0] host_addr = 10'h000;
	logic [7:0] host_data_in = 8'h00, host_data_out, host_data_oe, pin_vec, rnd = 8'h63;
	logic [1:0] status_mode = fdsr_pkg::FDSR_MODE_ENHANCED, tape_drive_sel;
	logic [5:0] cfg = 6'b010000;
	logic head_dir_inward = 1'b0, head_side_out = 1'b0, step_active = 1'b0, write_gate_out = 1'b0;
	logic write_data_active = 1'b0, dma_request_int = 1'b0, fdc_irq_int = 1'b0, input_reg_read = 1'b0;
	logic write_protect_in, index_in, track_zero_in, read_data_in_n, second_drive_present_in;
	logic dma_ack_in_n, terminal_count_in, dma_request_out, dma_request_oe, fdc_irq_out, fdc_irq_oe;
	logic dma_ack_gated_n, terminal_count_gated, drive_select0_out_n, drive_select1_out_n;
	logic motor0_out_n, motor1_out_n, soft_reset_n;
	logic [15:0] q[$];
	logic [15:0] note;
	int errors = 0, compares = 0, lowc = 0;

	always #4 clk = ~clk;
	assign pin_vec = {drive_select1_out_n, drive_select0_out_n, motor1_out_n, motor0_out_n, soft_reset_n,
		dma_request_oe, tape_drive_sel};

	fdsr_regs DUT (.clk, .rst, .host_addr, .host_rd_n, .host_wr_n, .host_data_in, .host_data_out, .host_data_oe,
		.status_mode, .drive_swap, .head_dir_inward, .head_side_out, .step_active, .write_gate_out,
		.write_data_active, .dma_request_int, .fdc_irq_int, .input_reg_read, .write_protect_in, .index_in,
		.track_zero_in, .read_data_in_n, .second_drive_present_in, .dma_ack_in_n, .terminal_count_in,
		.dma_request_out, .dma_request_oe, .fdc_irq_out, .fdc_irq_oe, .dma_ack_gated_n, .terminal_count_gated,
		.drive_select0_out_n, .drive_select1_out_n, .motor0_out_n, .motor1_out_n, .soft_reset_n, .tape_drive_sel);
	fdsr_drive_model u_drive (.clk, .rst, .cfg, .kick, .write_protect_in, .index_in, .track_zero_in,
		.read_data_in_n, .second_drive_present_in, .dma_ack_in_n, .terminal_count_in);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] lfsr(logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr

	task automatic give_verdict();
		if (errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Address and data held three clocks before and six clocks after the release
	task automatic wr(logic [9:0] a, logic [7:0] d);
		host_addr = a;
		host_data_in = d;
		host_wr_n = 1'b0;
		cyc(3);
		host_wr_n = 1'b1;
		cyc(6);
	endtask : wr

	task automatic rd(logic [9:0] a, logic [7:0] e, logic [7:0] m);
		host_addr = a;
		host_rd_n = 1'b0;
		q.push_back({m, e & m});
		cyc(6);
		host_rd_n = 1'b1;
		cyc(4);
	endtask : rd

	task automatic pulse_clear();
		input_reg_read = 1'b1;
		cyc(1);
		input_reg_read = 1'b0;
		cyc(2);
	endtask : pulse_clear

	// ==========================================================
	// Read result monitor, data valid on the fifth edge low
	always @(posedge clk)
	begin
		lowc = host_rd_n ? 0 : lowc + 1;
		if (lowc == 5)
		begin
			note = q.pop_front();
			chk("read oe", note[15:8], host_data_oe);
			chk("read data", note[7:0], host_data_out & host_data_oe);
		end
	end

	initial
	begin
		cyc(5000);
		errors++;
		give_verdict();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		cyc(10);
		rst = 1'b0;
		cyc(2);
		chk("pins", 8'hf4, pin_vec);
		rd(fdsr_pkg::OFS_DRIVE_OUT, 8'h00, 8'hff);
		wr(fdsr_pkg::OFS_DRIVE_OUT, 8'h1c);
		chk("pins", 8'hac, pin_vec);
		rd(fdsr_pkg::OFS_STATUS_B, 8'hc1, 8'hff);
		wr(fdsr_pkg::OFS_DRIVE_OUT, 8'h2d);
		chk("pins", 8'h5c, pin_vec);
		rd(fdsr_pkg::OFS_STATUS_B, 8'he2, 8'hff);
		drive_swap = 1'b1;
		cyc(2);
		chk("pins", 8'hac, pin_vec);
		drive_swap = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			wr(fdsr_pkg::OFS_TAPE, {rnd[7:2], i[1:0]});
			rd(fdsr_pkg::OFS_TAPE, {6'h00, i[1:0]}, 8'h03);
		end
		wr(fdsr_pkg::OFS_DRIVE_OUT, 8'h29);
		chk("pins", 8'h57, pin_vec);
		cyc(4); // soft reset held over 100ns
		wr(fdsr_pkg::OFS_DRIVE_OUT, 8'h2d);
		chk("pins", 8'h5f, pin_vec);
		rd(fdsr_pkg::OFS_DRIVE_OUT, 8'h2d, 8'hff);
		status_mode = fdsr_pkg::FDSR_MODE_ALTERNATE;
		cfg = 6'b010101;
		{head_dir_inward, head_side_out, dma_request_int, step_active} = 4'hf;
		cyc(2);
		step_active = 1'b0;
		cyc(4);
		chk("pin levels", 8'h02, {6'h00, dma_request_out, fdc_irq_out});
		rd(fdsr_pkg::OFS_STATUS_A, 8'h72, 8'hff);
		pulse_clear();
		rd(fdsr_pkg::OFS_STATUS_A, 8'h52, 8'hff);
		write_gate_out = 1'b1;
		cyc(2);
		write_gate_out = 1'b0;
		kick = 1'b1;
		cyc(1);
		kick = 1'b0;
		write_data_active = 1'b1;
		cyc(2);
		write_data_active = 1'b0;
		cyc(8);
		rd(fdsr_pkg::OFS_STATUS_B, 8'hbf, 8'hff);
		pulse_clear();
		rd(fdsr_pkg::OFS_STATUS_B, 8'ha3, 8'hff);
		status_mode = fdsr_pkg::FDSR_MODE_ENHANCED;
		cyc(2);
		rd(fdsr_pkg::OFS_STATUS_B, 8'hfa, 8'hff);
		status_mode = fdsr_pkg::FDSR_MODE_BASIC;
		cfg = 6'b100101;
		fdc_irq_int = 1'b1;
		cyc(4);
		rd(fdsr_pkg::OFS_STATUS_A, 8'h00, 8'h00);
		rd(fdsr_pkg::OFS_STATUS_B, 8'h00, 8'h00);
		rd(10'h3f5, 8'h00, 8'h00);
		chk("gating", 8'h0d, {4'h0, dma_request_oe, fdc_irq_oe, dma_ack_gated_n, terminal_count_gated});
		chk("pin levels", 8'h03, {6'h00, dma_request_out, fdc_irq_out});
		wr(fdsr_pkg::OFS_DRIVE_OUT, 8'h25);
		chk("gating", 8'h02, {4'h0, dma_request_oe, fdc_irq_oe, dma_ack_gated_n, terminal_count_gated});
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		cyc(2);
		rd(fdsr_pkg::OFS_DRIVE_OUT, 8'h00, 8'hff);
		rd(fdsr_pkg::OFS_TAPE, 8'h00, 8'h03);
		give_verdict();
	end
endmodule : tb

// >>> shared/fdsr_pkg.sv
package fdsr_pkg;

	// ==========================================================
	// Host register offsets
	localparam logic [9:0] OFS_STATUS_A = 10'h3f0;
	localparam logic [9:0] OFS_STATUS_B = 10'h3f1;
	localparam logic [9:0] OFS_DRIVE_OUT = 10'h3f2;
	localparam logic [9:0] OFS_TAPE = 10'h3f3;
	localparam int ADDR_W = 10;

	// ==========================================================
	// Output control register fields
	localparam int DOR_DSEL_LSB = 0;
	localparam int DOR_SRST_BIT = 2;
	localparam int DOR_DMA_PIN_ENABLE_BIT = 3;
	localparam int DOR_MOT0_BIT = 4;
	localparam int DOR_MOT1_BIT = 5;
	localparam logic [7:0] DOR_RST = 8'h00;
	localparam logic [1:0] TAPE_RST = 2'h0;
	localparam logic [1:0] SRB_FILL_ONES = 2'h3;
	localparam logic [7:0] TAPE_DRIVEN = 8'h03;

	// ==========================================================
	// Synchroniser vector layout
	localparam int SY_RD_N = 0;
	localparam int SY_WR_N = 1;
	localparam int SY_WP = 2;
	localparam int SY_INDEX = 3;
	localparam int SY_TRACK_ZERO_IN = 4;
	localparam int SY_RDATA_N = 5;
	localparam int SY_ACK_N = 6;
	localparam int SY_TC = 7;
	localparam int SY_SECOND_DRIVE_PRESENT_IN = 8;
	localparam int SY_DATA_LSB = 9;
	localparam int SY_ADDR_LSB = 17;
	localparam int SYNC_W = 27;
	// Idle-high pins start high so release of reset makes no edge
	localparam logic [SYNC_W-1:0] SYNC_RST = 27'h0000063;

	// ==========================================================
	// Status layout selection
	typedef enum logic [1:0] {
		FDSR_MODE_BASIC,
		FDSR_MODE_ENHANCED,
		FDSR_MODE_ALTERNATE
	} fdsr_mode_t;

endpackage : fdsr_pkg

// >>> shared/fdsr_sync_if.sv
`timescale 1ns/1ps

interface fdsr_sync_if;
	logic [fdsr_pkg::SYNC_W-1:0] raw;
	logic [fdsr_pkg::SYNC_W-1:0] level;
	logic [fdsr_pkg::SYNC_W-1:0] rise;
	logic [fdsr_pkg::SYNC_W-1:0] fall;

	modport src
	(
		output raw,
		input  level,
		input  rise,
		input  fall
	);

	modport sync
	(
		input  raw,
		output level,
		output rise,
		output fall
	);
endinterface : fdsr_sync_if

// >>> verilog/fdsr_pin_sync.sv
`timescale 1ns/1ps

module fdsr_pin_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pin bundle
	fdsr_sync_if.sync pins
);

	// ==========================================================
	// Two-stage capture plus one stage for edges
	logic [fdsr_pkg::SYNC_W-1:0] meta_reg;
	logic [fdsr_pkg::SYNC_W-1:0] stable_reg;
	logic [fdsr_pkg::SYNC_W-1:0] prev_reg;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg   <= fdsr_pkg::SYNC_RST;
			stable_reg <= fdsr_pkg::SYNC_RST;
			prev_reg   <= fdsr_pkg::SYNC_RST;
		end
		else
		begin
			meta_reg   <= pins.raw;
			stable_reg <= meta_reg;
			prev_reg   <= stable_reg;
		end
	end

	assign pins.level = stable_reg;
	assign pins.rise  = stable_reg & ~prev_reg;
	assign pins.fall  = ~stable_reg & prev_reg;

endmodule : fdsr_pin_sync

// >>> verilog/fdsr_regs.sv
`timescale 1ns/1ps

module fdsr_regs
#(
	parameter int ADDR_W = fdsr_pkg::ADDR_W
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Host I/O port
	input  wire logic [9:0]  host_addr,
	input  wire logic        host_rd_n,
	input  wire logic        host_wr_n,
	input  wire logic [7:0]  host_data_in,
	output logic      [7:0]  host_data_out,
	output logic      [7:0]  host_data_oe,
	// Configuration
	input  wire logic [1:0]  status_mode,
	input  wire logic        drive_swap,
	// Controller engine, same clock
	input  wire logic        head_dir_inward,
	input  wire logic        head_side_out,
	input  wire logic        step_active,
	input  wire logic        write_gate_out,
	input  wire logic        write_data_active,
	input  wire logic        dma_request_int,
	input  wire logic        fdc_irq_int,
	input  wire logic        input_reg_read,
	// Drive input pins
	input  wire logic        write_protect_in,
	input  wire logic        index_in,
	input  wire logic        track_zero_in,
	input  wire logic        read_data_in_n,
	input  wire logic        second_drive_present_in,
	// DMA and interrupt pins
	input  wire logic        dma_ack_in_n,
	input  wire logic        terminal_count_in,
	output logic             dma_request_out,
	output logic             dma_request_oe,
	output logic             fdc_irq_out,
	output logic             fdc_irq_oe,
	output logic             dma_ack_gated_n,
	output logic             terminal_count_gated,
	// Drive outputs
	output logic             drive_select0_out_n,
	output logic             drive_select1_out_n,
	output logic             motor0_out_n,
	output logic             motor1_out_n,
	output logic             soft_reset_n,
	output logic      [1:0]  tape_drive_sel
);

	// ==========================================================
	// Elaboration check
	if (ADDR_W != 10)
	begin : g_bad_addr
		$error("fdsr_regs: ADDR_W must be 10");
	end

	// ==========================================================
	// Pin synchronisers
	fdsr_sync_if sy ();

	assign sy.raw = {host_addr, host_data_in, second_drive_present_in, terminal_count_in,
		dma_ack_in_n, read_data_in_n, track_zero_in, index_in, write_protect_in,
		host_wr_n, host_rd_n};

	fdsr_pin_sync u_sync
	(
		.clk  (clk),
		.rst  (rst),
		.pins (sy)
	);

	logic [9:0] bus_addr;
	logic [7:0] bus_data;
	logic       rd_active;
	logic       wr_done;
	logic       mode_enh;
	logic       mode_alt;
	fdsr_pkg::fdsr_mode_t mode;

	assign bus_addr  = sy.level[fdsr_pkg::SY_ADDR_LSB +: 10];
	assign bus_data  = sy.level[fdsr_pkg::SY_DATA_LSB +: 8];
	assign rd_active = ~sy.level[fdsr_pkg::SY_RD_N];
	// Write taken at strobe release, when data is surely settled
	assign wr_done   = sy.rise[fdsr_pkg::SY_WR_N];
	assign mode      = fdsr_pkg::fdsr_mode_t'(status_mode);
	assign mode_enh  = (mode == fdsr_pkg::FDSR_MODE_ENHANCED);
	assign mode_alt  = (mode == fdsr_pkg::FDSR_MODE_ALTERNATE);

	// ==========================================================
	// Register state
	logic [7:0] dor_reg;
	logic [7:0] dor_next;
	logic [1:0] tape_reg;
	logic [1:0] tape_next;
	logic       step_latch_reg;
	logic       step_latch_next;
	logic       write_gate_out_latch_reg;
	logic       write_gate_out_latch_next;
	logic       rdata_latch_reg;
	logic       rdata_latch_next;
	logic       wdata_latch_reg;
	logic       wdata_latch_next;
	logic       rdata_tog_reg;
	logic       rdata_tog_next;
	logic       wdata_tog_reg;
	logic       wdata_tog_next;
	logic       step_prev_reg;
	logic       write_gate_out_prev_reg;
	logic       wdata_prev_reg;

	logic step_set;
	logic write_gate_out_set;
	logic wdata_fall;
	logic rdata_inact;

	assign step_set    = step_active & ~step_prev_reg;
	assign write_gate_out_set   = write_gate_out & ~write_gate_out_prev_reg;
	assign wdata_fall  = ~write_data_active & wdata_prev_reg;
	assign rdata_inact = sy.rise[fdsr_pkg::SY_RDATA_N];

	always_comb
	begin
		dor_next  = dor_reg;
		tape_next = tape_reg;
		if (wr_done && bus_addr == fdsr_pkg::OFS_DRIVE_OUT)
		begin
			dor_next = bus_data;
		end
		// tape drive number, drive 0 is code 00 meaning none
		if (wr_done && bus_addr == fdsr_pkg::OFS_TAPE)
		begin
			tape_next = bus_data[1:0];
		end
		// set wins over input read and soft reset
		step_latch_next = step_set |
			(step_latch_reg & ~input_reg_read & dor_reg[fdsr_pkg::DOR_SRST_BIT]);
		write_gate_out_latch_next = write_gate_out_set | (write_gate_out_latch_reg & ~input_reg_read);
		// data latches, write data not gated by write gate
		rdata_latch_next = rdata_inact | (rdata_latch_reg & ~input_reg_read);
		wdata_latch_next = wdata_fall | (wdata_latch_reg & ~input_reg_read);
		rdata_tog_next = rdata_tog_reg ^ rdata_inact;
		wdata_tog_next = wdata_tog_reg ^ wdata_fall;
	end

	// hardware reset only; soft reset leaves these alone except step_latch_reg, which it clears
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dor_reg         <= fdsr_pkg::DOR_RST;
			tape_reg        <= fdsr_pkg::TAPE_RST;
			step_latch_reg  <= 1'b0;
			write_gate_out_latch_reg <= 1'b0;
			rdata_latch_reg <= 1'b0;
			wdata_latch_reg <= 1'b0;
			rdata_tog_reg   <= 1'b0;
			wdata_tog_reg   <= 1'b0;
			step_prev_reg   <= 1'b0;
			write_gate_out_prev_reg  <= 1'b0;
			wdata_prev_reg  <= 1'b0;
		end
		else
		begin
			dor_reg         <= dor_next;
			tape_reg        <= tape_next;
			step_latch_reg  <= step_latch_next;
			write_gate_out_latch_reg <= write_gate_out_latch_next;
			rdata_latch_reg <= rdata_latch_next;
			wdata_latch_reg <= wdata_latch_next;
			rdata_tog_reg   <= rdata_tog_next;
			wdata_tog_reg   <= wdata_tog_next;
			step_prev_reg   <= step_active;
			write_gate_out_prev_reg  <= write_gate_out;
			wdata_prev_reg  <= write_data_active;
		end
	end

	// ==========================================================
	// Status bytes
	logic [7:0] status_a;
	logic [7:0] status_b;
	logic [1:0] dsel;
	logic       mot0;
	logic       mot1;

	assign dsel = dor_reg[fdsr_pkg::DOR_DSEL_LSB +: 2];
	assign mot0 = dor_reg[fdsr_pkg::DOR_MOT0_BIT];
	assign mot1 = dor_reg[fdsr_pkg::DOR_MOT1_BIT];

	always_comb
	begin
		if (mode_alt)
		begin
			status_a = {fdc_irq_int, dma_request_int, step_latch_reg,
				sy.level[fdsr_pkg::SY_TRACK_ZERO_IN], ~head_side_out,
				sy.level[fdsr_pkg::SY_INDEX], sy.level[fdsr_pkg::SY_WP],
				~head_dir_inward};
			status_b = {~sy.level[fdsr_pkg::SY_SECOND_DRIVE_PRESENT_IN], drive_select1_out_n,
				drive_select0_out_n, wdata_latch_reg, rdata_latch_reg,
				write_gate_out_latch_reg, fdsr_pkg::SRB_FILL_ONES};
		end
		else
		begin
			status_a = {fdc_irq_int, ~sy.level[fdsr_pkg::SY_SECOND_DRIVE_PRESENT_IN], step_active,
				~sy.level[fdsr_pkg::SY_TRACK_ZERO_IN], head_side_out,
				~sy.level[fdsr_pkg::SY_INDEX], ~sy.level[fdsr_pkg::SY_WP],
				head_dir_inward};
			status_b = {fdsr_pkg::SRB_FILL_ONES, dsel[0], wdata_tog_reg,
				rdata_tog_reg, write_gate_out, mot1, mot0};
		end
	end

	// ==========================================================
	// Drive decode
	logic sel0_n;
	logic sel1_n;
	logic sel0_raw;
	logic sel1_raw;

	// one binary drive number selects at most one drive
	assign sel0_raw = (dsel == 2'h0) & mot0;
	assign sel1_raw = (dsel == 2'h1) & mot1;

	always_comb
	begin
		if (drive_swap)
		begin
			sel0_n = ~sel1_raw;
			sel1_n = ~sel0_raw;
		end
		else
		begin
			sel0_n = ~sel0_raw;
			sel1_n = ~sel1_raw;
		end
	end

	// ==========================================================
	// Output registers
	logic [7:0] data_out_next;
	logic [7:0] data_oe_next;
	logic       pins_on;

	always_comb
	begin
		data_out_next = 8'h00;
		data_oe_next  = 8'h00;
		if (rd_active)
		begin
			case (bus_addr)
				// basic mode leaves status A floating
				fdsr_pkg::OFS_STATUS_A:
				begin
					data_out_next = status_a;
					data_oe_next  = (mode == fdsr_pkg::FDSR_MODE_BASIC) ? 8'h00 : 8'hff;
				end
				// status B floats in basic mode
				fdsr_pkg::OFS_STATUS_B:
				begin
					data_out_next = status_b;
					data_oe_next  = (mode == fdsr_pkg::FDSR_MODE_BASIC) ? 8'h00 : 8'hff;
				end
				fdsr_pkg::OFS_DRIVE_OUT:
				begin
					data_out_next = dor_reg;
					data_oe_next  = 8'hff;
				end
				fdsr_pkg::OFS_TAPE:
				begin
					data_out_next = {6'h00, tape_reg};
					data_oe_next  = fdsr_pkg::TAPE_DRIVEN;
				end
				default:
				begin
					data_out_next = 8'h00;
					data_oe_next  = 8'h00;
				end
			endcase
		end
		pins_on = mode_enh | dor_reg[fdsr_pkg::DOR_DMA_PIN_ENABLE_BIT];
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			host_data_out        <= 8'h00;
			host_data_oe         <= 8'h00;
			dma_request_out      <= 1'b0;
			fdc_irq_out          <= 1'b0;
			drive_select0_out_n  <= 1'b1;
			drive_select1_out_n  <= 1'b1;
			motor0_out_n         <= 1'b1;
			motor1_out_n         <= 1'b1;
			soft_reset_n         <= 1'b0;
			tape_drive_sel       <= fdsr_pkg::TAPE_RST;
		end
		else
		begin
			host_data_out        <= data_out_next;
			host_data_oe         <= data_oe_next;
			dma_request_out      <= dma_request_int;
			fdc_irq_out          <= fdc_irq_int;
			drive_select0_out_n  <= sel0_n;
			drive_select1_out_n  <= sel1_n;
			// motor outputs low-true, swapped with selects
			motor0_out_n         <= drive_swap ? ~mot1 : ~mot0;
			motor1_out_n         <= drive_swap ? ~mot0 : ~mot1;
			// soft reset follows the control bit
			soft_reset_n         <= dor_reg[fdsr_pkg::DOR_SRST_BIT];
			tape_drive_sel       <= tape_reg;
		end
	end

	// gating; no reset so enhanced mode stays enabled in reset
	always_ff @(posedge clk)
	begin
		dma_request_oe       <= pins_on;
		fdc_irq_oe           <= pins_on;
		dma_ack_gated_n      <= sy.level[fdsr_pkg::SY_ACK_N] | ~pins_on;
		terminal_count_gated <= sy.level[fdsr_pkg::SY_TC] & pins_on;
	end

endmodule : fdsr_regs
